//--- core/power_mode_map.vh
// constants for the power mode sequencer
// Contract
// - four power states ordered active, idle, sleep, deep power-off
// - after programmed inactivity interval, step down one power state
// - user activity in any lower state returns straight to active
// - deep power-off cuts core and pa supply rails, io domain stays on
// - always-on io logic watches user events in deep power-off and repowers
// - separate power-down outputs for tx path, rx path, pll, pa
// - packet handler enables rf sections only when needed in packet
// - low-power connection mode runs on slow oscillator, wakes after period
// - actions triggerable by software writes and by packet events
// - core regulator disabled on deep power-off entry under firmware control
`ifndef POWER_MODE_MAP_VH
`define POWER_MODE_MAP_VH
`define PM_ACTIVE 2'h0
`define PM_IDLE 2'h1
`define PM_SLEEP 2'h2
`define PM_DEEP_OFF 2'h3
`define PM_TMR_W 16
`define PM_TMR_ZERO 16'h0000
`define PM_TMR_ONE 16'h0001
`define PM_TMR_MAX 16'hffff
`define PM_MODE_STEP 2'h1
`define PM_IDLE_TICKS 16'h0064
`define PM_SLEEP_TICKS 16'h03e8
`define PM_DEEP_TICKS 16'h2710
`define PM_LP_TICKS 16'h0100
`define PM_LPO_DIV 8'h4e
`define PM_DIV_ZERO 8'h00
`define PM_DIV_ONE 8'h01
`endif

//--- core/lpo_tick_divider.v
// slow oscillator tick divider
`timescale 1ns/1ps
`include "power_mode_map.vh"
module lpo_tick_divider #(
   parameter [7:0] DIV = `PM_LPO_DIV
) (
   input wire clk,
   input wire rst_n,
   output reg tick_ff
);
   reg [7:0] cnt_ff;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= `PM_DIV_ZERO;
         tick_ff <= 1'b0;
      end else if (cnt_ff == DIV) begin
         cnt_ff <= `PM_DIV_ZERO;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + `PM_DIV_ONE;
         tick_ff <= 1'b0;
      end
   end
endmodule // lpo_tick_divider

//--- core/power_mode_sequencer.v
// power mode sequencer with rf power-down control
`timescale 1ns/1ps
`include "power_mode_map.vh"
module power_mode_sequencer #(
   parameter [7:0] LPO_DIV = `PM_LPO_DIV
) (
   input wire clk,
   input wire rst_n,
   input wire user_event,
   input wire [15:0] idle_ticks,
   input wire [15:0] sleep_ticks,
   input wire [15:0] deep_ticks,
   input wire sw_force_valid,
   input wire [1:0] sw_force_mode,
   input wire fw_regulator_off_en,
   input wire lp_conn_req,
   input wire [15:0] lp_conn_ticks,
   input wire pkt_tx_busy,
   input wire pkt_rx_busy,
   input wire pkt_pa_need,
   input wire pkt_idle_event,
   output reg [1:0] power_mode_ff,
   output reg core_supply_rail_en_ff,
   output reg pa_supply_rail_en_ff,
   output reg core_regulator_en_ff,
   output reg tx_pd_ff,
   output reg rx_pd_ff,
   output reg pll_pd_ff,
   output reg pa_pd_ff,
   output reg lp_conn_active_ff,
   output reg lp_wake_ff
);
   wire lpo_tick;
   reg [15:0] tmr_ff;
   reg [15:0] lp_tmr_ff;
   reg [1:0] nxt_mode;
   reg [15:0] limit;
   reg step_down;

   // slow oscillator ticks pace every interval
   lpo_tick_divider #(.DIV(LPO_DIV)) u_div (
      .clk(clk),
      .rst_n(rst_n),
      .tick_ff(lpo_tick)
   );

   function [15:0] interval_of;
      input [1:0] mode;
      input [15:0] a;
      input [15:0] b;
      input [15:0] c;
      begin
         case (mode)
            `PM_ACTIVE: interval_of = a;
            `PM_IDLE: interval_of = b;
            `PM_SLEEP: interval_of = c;
            default: interval_of = `PM_TMR_ZERO;
         endcase
      end
   endfunction

   always @* begin
      limit = interval_of(power_mode_ff, idle_ticks, sleep_ticks, deep_ticks);
      step_down = (power_mode_ff != `PM_DEEP_OFF) && lpo_tick &&
                  (tmr_ff + `PM_TMR_ONE >= limit);
      nxt_mode = power_mode_ff;
      if (user_event) begin
         nxt_mode = `PM_ACTIVE;
      end else if (sw_force_valid) begin
         nxt_mode = sw_force_mode;
      end else if (pkt_idle_event && power_mode_ff == `PM_ACTIVE) begin
         nxt_mode = `PM_IDLE;
      end else if (step_down) begin
         nxt_mode = power_mode_ff + `PM_MODE_STEP;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         power_mode_ff <= `PM_ACTIVE;
         tmr_ff <= `PM_TMR_ZERO;
      end else begin
         power_mode_ff <= nxt_mode;
         // user activity or a new mode restarts the interval
         if (user_event || nxt_mode != power_mode_ff) begin
            tmr_ff <= `PM_TMR_ZERO;
         end else if (lpo_tick && tmr_ff != `PM_TMR_MAX) begin
            tmr_ff <= tmr_ff + `PM_TMR_ONE;
         end
      end
   end

   // rails follow the mode; io domain logic (this block) stays powered
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_supply_rail_en_ff <= 1'b1;
         pa_supply_rail_en_ff <= 1'b1;
         core_regulator_en_ff <= 1'b1;
      end else begin
         core_supply_rail_en_ff <= (nxt_mode != `PM_DEEP_OFF);
         pa_supply_rail_en_ff <= (nxt_mode != `PM_DEEP_OFF);
         // firmware may keep the regulator on, e.g. for debug
         core_regulator_en_ff <= !(nxt_mode == `PM_DEEP_OFF && fw_regulator_off_en);
      end
   end

   // rf sections powered only while the packet needs them and the next mode is active
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_pd_ff <= 1'b1;
         rx_pd_ff <= 1'b1;
         pll_pd_ff <= 1'b1;
         pa_pd_ff <= 1'b1;
      end else begin
         tx_pd_ff <= !(pkt_tx_busy && nxt_mode == `PM_ACTIVE);
         rx_pd_ff <= !(pkt_rx_busy && nxt_mode == `PM_ACTIVE);
         pll_pd_ff <= !((pkt_tx_busy || pkt_rx_busy) && nxt_mode == `PM_ACTIVE);
         pa_pd_ff <= !(pkt_tx_busy && pkt_pa_need && nxt_mode == `PM_ACTIVE);
      end
   end

   // low-power connection: counts slow ticks, one-cycle wake at expiry
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lp_conn_active_ff <= 1'b0;
         lp_tmr_ff <= `PM_TMR_ZERO;
         lp_wake_ff <= 1'b0;
      end else begin
         lp_wake_ff <= 1'b0;
         if (!lp_conn_req) begin
            lp_conn_active_ff <= 1'b0;
            lp_tmr_ff <= `PM_TMR_ZERO;
         end else if (!lp_conn_active_ff) begin
            lp_conn_active_ff <= 1'b1;
            lp_tmr_ff <= `PM_TMR_ZERO;
         end else if (lpo_tick) begin
            if (lp_tmr_ff + `PM_TMR_ONE >= lp_conn_ticks) begin
               lp_tmr_ff <= `PM_TMR_ZERO;
               lp_wake_ff <= 1'b1;
            end else begin
               lp_tmr_ff <= lp_tmr_ff + `PM_TMR_ONE;
            end
         end
      end
   end
endmodule // power_mode_sequencer

//--- tb/rf_xcvr_model.sv
// rf transceiver stand-in
`timescale 1ns/1ps
module rf_xcvr_model (
   input logic [3:0] pd,
   output logic rf_on
);
   assign rf_on = pd != 4'hf;
endmodule // rf_xcvr_model

//--- tb/pms_chk.sv
// power mode checker
`timescale 1ns/1ps
module pms_chk (
   input logic clk,
   input logic rst_n,
   input logic user_event,
   input logic sw_force_valid,
   input logic [1:0] sw_force_mode,
   input logic [1:0] power_mode_ff,
   input logic core_supply_rail_en_ff,
   input logic pa_supply_rail_en_ff,
   input logic core_regulator_en_ff,
   input logic tx_pd_ff,
   input logic rx_pd_ff,
   input logic pll_pd_ff,
   input logic pa_pd_ff,
   input logic lp_wake_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_WAKE: assert property (user_event |=> power_mode_ff == 2'h0) else $error("w");
   AST_FORCE: assert property (sw_force_valid && !user_event |=>
      power_mode_ff == $past(sw_force_mode)) else $error("f");
   AST_STEP: assert property (power_mode_ff != $past(power_mode_ff) && !$past(sw_force_valid)
      |-> power_mode_ff == 2'h0 || power_mode_ff == $past(power_mode_ff) + 2'h1) else $error("s");
   AST_HOLD: assert property (power_mode_ff == 2'h3 && !user_event && !sw_force_valid |=>
      power_mode_ff == 2'h3) else $error("h");
   AST_RAIL: assert property (core_supply_rail_en_ff == (power_mode_ff != 2'h3)) else $error("r");
   AST_PD: assert property (power_mode_ff != 2'h0 && $past(power_mode_ff) != 2'h0 |->
      tx_pd_ff && rx_pd_ff && pll_pd_ff && pa_pd_ff) else $error("p");
   AST_PLL: assert property (!tx_pd_ff || !rx_pd_ff |-> !pll_pd_ff) else $error("l");
   AST_LPW: assert property (lp_wake_ff |=> !lp_wake_ff) else $error("k");
   AST_PARAIL: assert property (pa_supply_rail_en_ff == core_supply_rail_en_ff) else $error("a");
   AST_REG: assert property (power_mode_ff != 2'h3 |-> core_regulator_en_ff) else $error("g");
endmodule // pms_chk
bind power_mode_sequencer pms_chk chk_u (.*);

//--- tb/tb_power_mode_sequencer.sv
// power mode bench
`timescale 1ns/1ps
module tb_power_mode_sequencer;
   logic clk, rst_n, user_event, sw_force_valid, fw_regulator_off_en, lp_conn_req;
   logic pkt_tx_busy, pkt_rx_busy, pkt_pa_need, pkt_idle_event;
   logic [1:0] sw_force_mode, e, prev = 2'h0, q[$];
   logic [15:0] idle_ticks, sleep_ticks, deep_ticks, lp_conn_ticks;
   logic [31:0] r = 32'h761b;
   wire [1:0] power_mode_ff;
   wire core_supply_rail_en_ff, pa_supply_rail_en_ff, core_regulator_en_ff, tx_pd_ff, rx_pd_ff;
   wire pll_pd_ff, pa_pd_ff, lp_conn_active_ff, lp_wake_ff, rf_on;
   int fails = 0, n_compared = 0, gap = 0;
   logic tx_s = 1'b0, rx_s = 1'b0, pa_s = 1'b0, rst_q = 1'b0, seen = 1'b0, act;
   logic [3:0] exp_pd;
   // wake spacing: lp_conn_ticks slow ticks of LPO_DIV+1 clocks each
   localparam int LP_GAP = 2 * 4;
   // short tick keeps the walk through all modes brief
   power_mode_sequencer #(.LPO_DIV(8'h03)) dut_u (.*);
   rf_xcvr_model xcvr_u (.pd({tx_pd_ff, rx_pd_ff, pll_pd_ff, pa_pd_ff}), .rf_on(rf_on));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction
   task summarize;
      if (fails == 0 && n_compared > 0 && q.size() == 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task step(input logic [1:0] m, input logic [2:0] ufp);
      q.push_back(m);
      {user_event, sw_force_valid, pkt_idle_event, sw_force_mode} = {ufp, m};
      @(posedge clk) #1;
      {user_event, sw_force_valid, pkt_idle_event} = 3'h0;
      repeat (4) @(posedge clk) #1;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) #1 {r, pkt_tx_busy, pkt_rx_busy, pkt_pa_need} = {xs(r), r[2:0]};
   always @(posedge clk) begin
      prev <= power_mode_ff;
      rst_q <= rst_n;
      tx_s <= pkt_tx_busy;
      rx_s <= pkt_rx_busy;
      pa_s <= pkt_pa_need;
      // pd outputs reflect the packet levels sampled one edge back
      act = (power_mode_ff === 2'h0);
      exp_pd = {!(tx_s && act), !(rx_s && act), !((tx_s || rx_s) && act), !(tx_s && pa_s && act)};
      if (rst_q) begin
         n_compared++;
         if ({tx_pd_ff, rx_pd_ff, pll_pd_ff, pa_pd_ff, rf_on} !== {exp_pd, exp_pd != 4'hf}) begin
            fails++;
            $display("unexpected %0t pd %h", $time, {tx_pd_ff, rx_pd_ff, pll_pd_ff, pa_pd_ff});
         end
      end
      if (rst_q && lp_wake_ff === 1'b1) begin
         if (seen) begin
            n_compared++;
            if (gap != LP_GAP || lp_conn_active_ff !== 1'b1) begin
               fails++;
               $display("unexpected %0t wake gap %0d", $time, gap);
            end
         end
         seen <= 1'b1;
         gap <= 1;
      end else begin
         gap <= gap + 1;
      end
      if (rst_n && power_mode_ff !== prev) begin
         e = q.pop_front();
         n_compared++;
         if ({power_mode_ff, core_supply_rail_en_ff, pa_supply_rail_en_ff, core_regulator_en_ff}
            !== {e, e != 2'h3, e != 2'h3, !(e == 2'h3 && fw_regulator_off_en)}) begin
            fails++;
            $display("unexpected %0t mode %h", $time, power_mode_ff);
         end
      end
   end
   initial begin
      {rst_n, user_event, sw_force_valid, pkt_idle_event, lp_conn_req, sw_force_mode} = 7'h0;
      {pkt_tx_busy, pkt_rx_busy, pkt_pa_need, fw_regulator_off_en} = 4'h1;
      {idle_ticks, sleep_ticks, deep_ticks, lp_conn_ticks} = {16'h1, 16'h2, 16'h1, 16'h2};
      repeat (16) @(posedge clk) #1;
      rst_n = 1'b1;
      q = '{2'h1, 2'h2, 2'h3};
      repeat (40) @(posedge clk) #1;
      // long intervals so no timer step races the forced changes
      {idle_ticks, sleep_ticks, deep_ticks} = {3{r[15:0] | 16'h1000}};
      step(2'h0, 3'h4);
      for (int m = 1; m < 4; m++) step(m[1:0], 3'h2);
      step(2'h0, 3'h7);
      step(2'h1, 3'h1);
      step(2'h0, 3'h4);
      // firmware keeps the regulator up through a deep off
      fw_regulator_off_en = 1'b0;
      step(2'h3, 3'h2);
      step(2'h0, 3'h4);
      lp_conn_req = 1'b1;
      repeat (60) @(posedge clk) #1;
      summarize();
   end
   initial begin
      #60000 fails++;
      summarize();
   end
endmodule // tb_power_mode_sequencer
